// >>> shared/adc_link_pkg.sv
// constants and carrier types for the stereo converter serial link
package adc_link_pkg;
   // clock plan of the link
   localparam int MCLK_HZ = 24576000;
   localparam int FS_HZ = 48000;
   localparam int BCLK_HZ = 3072000;
   localparam int MCLK_PER_FS = MCLK_HZ / FS_HZ;
   localparam int MCLK_PER_BIT = MCLK_HZ / BCLK_HZ;
   localparam int BITS_PER_FRAME = BCLK_HZ / FS_HZ;
   localparam int SLOT_BITS = 32;
   localparam int SAMPLE_BITS = 24;
   localparam int CNT_W = $clog2(MCLK_PER_FS);
   localparam int PHASE_W = $clog2(MCLK_PER_BIT);
   localparam int SLOT_W = $clog2(SLOT_BITS);
   // field positions inside the mclk counter
   localparam int BCLK_POS = PHASE_W - 1;
   localparam int CHAN_POS = CNT_W - 1;
   localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
   localparam logic [CNT_W-1:0] CNT_LATCH = 9'h1f0;
   localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h7;
   localparam logic [SLOT_W-1:0] SAMPLE_END = 5'h18;
   // detector and band switch codes
   localparam int CAPS = 4;
   localparam int BANDS = 4;
   localparam logic [CAPS-1:0] CAP_RESET = 4'h1;
   localparam logic [BANDS-1:0] BAND_RESET = 4'h1;
   localparam logic [1:0] BAND_CODE_RESET = 2'h0;

   typedef logic [SAMPLE_BITS-1:0] sample_t;

   typedef struct packed {
      sample_t left;
      sample_t right;
   } sample_pair_s;

   typedef struct packed {
      logic bitClock;
      logic frameClock;
      logic serialData;
   } link_out_s;
endpackage

// >>> src/stereo_adc_serial_audio_rx.sv
// converter side of the serial audio link with detector and band switch control
`timescale 1ns/1ps

module stereo_adc_serial_audio_rx (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // master clock from the controller
   input wire logic clkMaster,
   // converted samples, system domain
   input wire adc_link_pkg::sample_pair_s sampleIn,
   input wire logic sampleValid,
   output logic sampleReady,
   // serial link pins
   output adc_link_pkg::link_out_s linkOut,
   // quadrature local oscillator pins
   input wire logic lo_phase_a,
   input wire logic lo_phase_b,
   // detector capacitor switch
   output logic [adc_link_pkg::CAPS-1:0] capSelect,
   // band code pins and band switch enables
   input wire logic [1:0] bandCode,
   output logic [adc_link_pkg::BANDS-1:0] bandSectionA,
   output logic [adc_link_pkg::BANDS-1:0] bandSectionB
);

   // reset release, system domain
   logic [1:0] rstPipe_reg;
   logic rstn;
   // reset release, link domain
   logic [1:0] linkRstPipe_reg;
   logic linkRstn;
   // sample hand-over, system side
   adc_link_pkg::sample_pair_s hold_reg;
   logic reqToggle_reg;
   logic ackSync1_reg;
   logic ackSync2_reg;
   logic accept;
   // sample hand-over, link side
   logic reqSync1_reg;
   logic reqSync2_reg;
   logic reqSeen_reg;
   adc_link_pkg::sample_pair_s pending_reg;
   adc_link_pkg::sample_pair_s frame_reg;
   // link timing
   logic [adc_link_pkg::CNT_W-1:0] cnt_reg;
   logic [adc_link_pkg::CNT_W-1:0] cnt_next;
   logic bitClock_reg;
   logic frameClock_reg;
   logic serialData_reg;
   logic serialData_next;
   // pin synchronisers
   logic [2:0] loA_reg;
   logic [2:0] loB_reg;
   logic [1:0] bandSync1_reg;
   logic [1:0] bandSync2_reg;
   logic [1:0] bandSync3_reg;
   logic [adc_link_pkg::CAPS-1:0] capSelect_reg;
   logic [adc_link_pkg::BANDS-1:0] band_reg;

   // one capacitor per quarter of the oscillator cycle
   function automatic logic [3:0] quarter_decode(input logic a, input logic b);
      case ({a, b})
         2'b00: quarter_decode = 4'h1;
         2'b10: quarter_decode = 4'h2;
         2'b11: quarter_decode = 4'h4;
         2'b01: quarter_decode = 4'h8;
         default: quarter_decode = 4'h1;
      endcase
   endfunction

   function automatic logic [3:0] band_decode(input logic [1:0] code);
      band_decode = 4'h1 << code;
   endfunction

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstPipe_reg <= 2'h0;
      end else begin
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
      end
   end
   assign rstn = rstPipe_reg[1];

   always_ff @(posedge clkMaster or negedge resetn) begin
      if (!resetn) begin
         linkRstPipe_reg <= 2'h0;
      end else begin
         linkRstPipe_reg <= {linkRstPipe_reg[0], 1'b1};
      end
   end
   assign linkRstn = linkRstPipe_reg[1];

   // system side of the toggle hand-over
   assign sampleReady = (ackSync2_reg == reqToggle_reg) && rstn;
   assign accept = sampleValid && sampleReady;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold_reg <= '0;
         reqToggle_reg <= 1'b0;
      end else if (accept) begin
         hold_reg <= sampleIn;
         reqToggle_reg <= ~reqToggle_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ackSync1_reg <= 1'b0;
         ackSync2_reg <= 1'b0;
      end else begin
         ackSync1_reg <= reqSeen_reg;
         ackSync2_reg <= ackSync1_reg;
      end
   end

   // link side: hold stays stable until the ack returns
   always_ff @(posedge clkMaster or negedge linkRstn) begin
      if (!linkRstn) begin
         reqSync1_reg <= 1'b0;
         reqSync2_reg <= 1'b0;
         reqSeen_reg <= 1'b0;
         pending_reg <= '0;
      end else begin
         reqSync1_reg <= reqToggle_reg;
         reqSync2_reg <= reqSync1_reg;
         if (reqSync2_reg != reqSeen_reg) begin
            reqSeen_reg <= reqSync2_reg;
            pending_reg <= hold_reg;
         end
      end
   end

   // mclk counter: 8 per bit, 512 per frame
   assign cnt_next = cnt_reg + 9'h001;

   always_ff @(posedge clkMaster or negedge linkRstn) begin
      if (!linkRstn) begin
         cnt_reg <= adc_link_pkg::CNT_RESET;
         bitClock_reg <= 1'b0;
         frameClock_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         bitClock_reg <= cnt_next[adc_link_pkg::BCLK_POS];
         frameClock_reg <= cnt_next[adc_link_pkg::CHAN_POS];
      end
   end

   // pair latched late in the right slot, after its sample bits are out
   always_ff @(posedge clkMaster or negedge linkRstn) begin
      if (!linkRstn) begin
         frame_reg <= '0;
      end else if (cnt_reg == adc_link_pkg::CNT_LATCH) begin
         frame_reg <= pending_reg;
      end
   end

   // next bit chosen for the slot that starts at the coming falling edge
   always_comb begin
      logic [adc_link_pkg::SLOT_W-1:0] slotBit;
      adc_link_pkg::sample_t word;
      slotBit = cnt_next[adc_link_pkg::CHAN_POS-1:adc_link_pkg::PHASE_W];
      word = cnt_next[adc_link_pkg::CHAN_POS] ? frame_reg.right : frame_reg.left;
      serialData_next = 1'b0;
      if (slotBit < adc_link_pkg::SAMPLE_END) begin
         serialData_next = word[5'(adc_link_pkg::SAMPLE_BITS - 1) - slotBit];
      end
   end

   always_ff @(posedge clkMaster or negedge linkRstn) begin
      if (!linkRstn) begin
         serialData_reg <= 1'b0;
      end else if (cnt_reg[adc_link_pkg::PHASE_W-1:0] == adc_link_pkg::PHASE_LAST) begin
         serialData_reg <= serialData_next;
      end
   end

   assign linkOut = '{bitClock: bitClock_reg, frameClock: frameClock_reg,
                      serialData: serialData_reg};

   // detector commutation from the quadrature oscillator pins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         loA_reg <= 3'h0;
         loB_reg <= 3'h0;
      end else begin
         loA_reg <= {loA_reg[1:0], lo_phase_a};
         loB_reg <= {loB_reg[1:0], lo_phase_b};
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         capSelect_reg <= adc_link_pkg::CAP_RESET;
      end else if (loA_reg[1] == loA_reg[2] && loB_reg[1] == loB_reg[2]) begin
         capSelect_reg <= quarter_decode(loA_reg[2], loB_reg[2]);
      end
   end
   assign capSelect = capSelect_reg;

   // band code drives both switch sections from one decode
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bandSync1_reg <= adc_link_pkg::BAND_CODE_RESET;
         bandSync2_reg <= adc_link_pkg::BAND_CODE_RESET;
         bandSync3_reg <= adc_link_pkg::BAND_CODE_RESET;
      end else begin
         bandSync1_reg <= bandCode;
         bandSync2_reg <= bandSync1_reg;
         bandSync3_reg <= bandSync2_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         band_reg <= adc_link_pkg::BAND_RESET;
      end else if (bandSync2_reg == bandSync3_reg) begin
         band_reg <= band_decode(bandSync3_reg);
      end
   end
   assign bandSectionA = band_reg;
   assign bandSectionB = band_reg;

   // checks
   bit_clock_period_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      $rose(bitClock_reg) |-> bitClock_reg [*4] ##1 !bitClock_reg)
      else $error("bit clock high phase is not four master clocks");

   frame_clock_edge_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      $changed(frameClock_reg) |-> cnt_reg[adc_link_pkg::CHAN_POS-1:0] == 8'h00)
      else $error("frame clock changed away from a slot boundary");

   data_stable_high_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      bitClock_reg && $past(bitClock_reg) |-> $stable(serialData_reg))
      else $error("serial data moved while bit clock was high");

   unused_bits_zero_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      cnt_reg[adc_link_pkg::CHAN_POS-1:adc_link_pkg::PHASE_W] >= adc_link_pkg::SAMPLE_END
      |-> !serialData_reg)
      else $error("unused slot bit is not zero");

   msb_first_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      cnt_reg == 9'h104 |-> serialData_reg == frame_reg.right[adc_link_pkg::SAMPLE_BITS-1])
      else $error("right slot does not open with its top bit");

   handover_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      accept |=> !sampleReady [*2])
      else $error("ready came back before the link saw the sample");

   cap_onehot_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $onehot(capSelect_reg))
      else $error("capacitor switch is not one-hot");

   cap_rotation_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $changed(capSelect_reg) |->
      capSelect_reg == {$past(capSelect_reg[2:0]), $past(capSelect_reg[3])}
      || capSelect_reg == {$past(capSelect_reg[0]), $past(capSelect_reg[3:1])})
      else $error("capacitor switch skipped a quarter");

   cap_settle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      loA_reg[1] == loA_reg[2] && loB_reg[1] == loB_reg[2]
      |=> capSelect_reg == quarter_decode($past(loA_reg[2]), $past(loB_reg[2])))
      else $error("capacitor switch does not follow the settled phase");

   band_onehot_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $onehot(band_reg))
      else $error("band switch is not one-hot");

   band_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      bandSync2_reg == bandSync3_reg
      |=> band_reg == band_decode($past(bandSync3_reg)))
      else $error("band switch does not follow the settled code");

   bit_clock_low_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      $fell(bitClock_reg) |-> !bitClock_reg [*4] ##1 bitClock_reg)
      else $error("bit clock low phase is not four master clocks");

   frame_wrap_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      cnt_reg == 9'h1ff |=> cnt_reg == adc_link_pkg::CNT_RESET)
      else $error("frame counter did not wrap after 512 master clocks");

   serial_edge_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      $changed(serialData_reg) |-> $fell(bitClock_reg))
      else $error("serial data moved away from a falling bit clock");

   left_msb_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      cnt_reg == 9'h004 |-> serialData_reg == frame_reg.left[adc_link_pkg::SAMPLE_BITS-1])
      else $error("left slot does not open with its top bit");

   frame_latch_a: assert property (@(posedge clkMaster) disable iff (!linkRstn)
      cnt_reg == adc_link_pkg::CNT_LATCH |=> frame_reg == $past(pending_reg))
      else $error("frame pair not taken from the pending pair");

endmodule

// >>> testbench/audio_slave_model.sv
// controller side model: master clock source and slave receiver of the serial link
`timescale 1ns/1ps
module audio_slave_model (
   // master clock to the converter
   output logic clkMaster,
   // link pins from the converter
   input wire logic bitClock,
   input wire logic frameClock,
   input wire logic serialData,
   // recovered pairs and frame measures
   output adc_link_pkg::sample_pair_s rxPair,
   output int rxCount,
   output int bitsPerFrame,
   output int mclkPerFrame
);
   logic lastFc = 1'b1;
   logic lastFcM = 1'b1;
   int idx = 0;
   int bitsSeen = 0;
   int mclks = 0;
   adc_link_pkg::sample_t shiftReg = '0;
   // controller gathers received pairs in blocks of 32
   adc_link_pkg::sample_pair_s pairBlock [32];
   int fill = 0;
   initial begin
      rxCount = 0;
      bitsPerFrame = 0;
      mclkPerFrame = 0;
      rxPair = '0;
      clkMaster = 1'b0;
      #17;
      forever #62.5 clkMaster = ~clkMaster;
   end
   // slave: samples only on the converter's bit clock
   always @(posedge bitClock) begin
      if (frameClock !== lastFc) idx = 0;
      else idx = idx + 1;
      if (frameClock === 1'b0 && lastFc === 1'b1) begin
         bitsPerFrame = bitsSeen;
         bitsSeen = 0;
      end
      bitsSeen = bitsSeen + 1;
      lastFc = frameClock;
      if (idx < 24) shiftReg = {shiftReg[22:0], serialData};
      if (idx == 23 && frameClock === 1'b0) rxPair.left = shiftReg;
      if (idx == 23 && frameClock === 1'b1) begin
         rxPair.right = shiftReg;
         pairBlock[fill] = rxPair;
         fill = (fill + 1) % 32;
         rxCount = rxCount + 1;
      end
   end
   // off the launching edge so frame clock is settled
   always @(negedge clkMaster) begin
      mclks = mclks + 1;
      if (lastFcM === 1'b1 && frameClock === 1'b0) begin
         mclkPerFrame = mclks;
         mclks = 0;
      end
      lastFcM = frameClock;
   end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the converter side of the serial audio link
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, resetn, clkMaster, sampleValid, sampleReady, loA, loB;
   logic [1:0] bandCode;
   logic [3:0] capSelect, secA, secB;
   adc_link_pkg::sample_pair_s sampleIn, rxPair, expPair;
   adc_link_pkg::link_out_s linkOut;
   int failures = 0, check_count = 0, cycles = 0;
   int rxCount, bitsPerFrame, mclkPerFrame;

   stereo_adc_serial_audio_rx uut (.clk_sys(clk_sys), .resetn(resetn), .clkMaster(clkMaster),
      .sampleIn(sampleIn), .sampleValid(sampleValid), .sampleReady(sampleReady),
      .linkOut(linkOut), .lo_phase_a(loA), .lo_phase_b(loB), .capSelect(capSelect),
      .bandCode(bandCode), .bandSectionA(secA), .bandSectionB(secB));
   audio_slave_model partner (.clkMaster(clkMaster), .bitClock(linkOut.bitClock),
      .frameClock(linkOut.frameClock), .serialData(linkOut.serialData), .rxPair(rxPair),
      .rxCount(rxCount), .bitsPerFrame(bitsPerFrame), .mclkPerFrame(mclkPerFrame));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 85000) begin
         failures = failures + 1;
         $display("MISMATCH %0t run timed out", $time);
         test_done();
      end
   end

   task automatic chkPair(input adc_link_pkg::sample_pair_s got,
                          input adc_link_pkg::sample_pair_s exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t pair got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkSel(input logic [3:0] got, input logic [3:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chkNum(input int got, input int exp, input string what);
      check_count++;
      if (got != exp) begin
         failures++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   function automatic logic [3:0] capFor(input logic [1:0] ab);
      case (ab)
         2'b00: return 4'h1;
         2'b10: return 4'h2;
         2'b11: return 4'h4;
         default: return 4'h8;
      endcase
   endfunction

   // hand over one pair, then offer junk while ready is low: it must be refused
   task automatic sendPair(input adc_link_pkg::sample_pair_s p);
      int k;
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      sampleIn <= p;
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while (sampleReady !== 1'b1 && k < 1000);
      @(posedge clk_sys);
      sampleIn <= ~p;
      for (k = 0; k < 3; k++) begin
         @(negedge clk_sys);
         chkSel({3'h0, sampleReady}, 4'h0, "ready after accept");
      end
      @(posedge clk_sys);
      sampleValid <= 1'b0;
   endtask

   task automatic waitRx;
      int n;
      int k;
      n = rxCount;
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while (rxCount == n && k < 20000);
   endtask

   initial begin
      resetn = 1'b0;
      sampleValid = 1'b0;
      sampleIn = '0;
      loA = 1'b0;
      loB = 1'b0;
      bandCode = 2'h0;
      void'($urandom(32'hdbfebe68));
      repeat (5) @(posedge clkMaster);
      chkSel(capSelect, 4'h1, "cap in reset");
      chkSel(secA, 4'h1, "band in reset");
      chkSel({3'h0, sampleReady}, 4'h0, "ready in reset");
      @(posedge clk_sys);
      resetn <= 1'b1;
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         // quadrature order: one oscillator pin moves per step
         {loA, loB} <= i[1:0] ^ (i[1:0] >> 1);
         bandCode <= i[1:0];
         repeat (8) @(posedge clk_sys);
         @(negedge clk_sys);
         chkSel(capSelect, capFor(i[1:0] ^ (i[1:0] >> 1)), "cap select");
         chkSel(secA, 4'h1 << i, "band section a");
         chkSel(secB, 4'h1 << i, "band section b");
      end
      $display("switch test done");
      waitRx();
      for (int i = 0; i < 4; i++) begin
         expPair.left = (i == 0) ? 24'h800000 : 24'($urandom());
         expPair.right = (i == 0) ? 24'h7fffff : 24'($urandom());
         sendPair(expPair);
         waitRx();
         chkPair(rxPair, expPair);
         chkPair(partner.pairBlock[(rxCount - 1) % 32], expPair);
      end
      $display("pair test done");
      chkNum(bitsPerFrame, 64, "bits per frame");
      chkNum(mclkPerFrame, 512, "master clocks per frame");
      $display("frame test done");
      test_done();
   end
endmodule
